// ---- sfw_regs.svh ----
// Constants for the serial flash latch, identification and status front-end
// Functional notes
// R1 - Latch-set instruction framed by chip select sets the write latch flag
// R2 - Program, erase and status write need a freshly set latch, refused otherwise
// R3 - Latch-clear instruction framed by chip select clears the write latch flag
// R4 - Latch clears on power-up, suspend, soft reset and completed modifying commands
// R5 - Identification read returns maker byte then two device bytes, 24 bits
// R6 - Identification read not decoded while busy; ongoing operation is unaffected
// R7 - Identification bytes driven on falling clock edges until chip select rises
// R8 - Legacy signature byte repeats while host keeps clocking with chip select low
// R9 - New host designs should prefer identification read over legacy signature
// R10 - Pair read: opcode, two dummy bytes, then one address byte
// R11 - Pair read MSB first; address bit 0 selects which byte comes first
// R12 - Pair read alternates the two bytes until chip select rises
// R13 - Status read accepted at any time, even while busy
// R14 - Host should check busy flag before new instructions during operations
// R15 - Status bit 0 is busy, one during program, erase or status write
// R16 - Status bit 1 is the write latch, gating program, erase and status write
// R17 - Program or erase targeting the protected area is ignored
// R18 - Host polls busy to zero, then checks latch reads zero
// R19 - Bits 5 to 2 are protect level, reset zero, changed only by status write
// R20 - Chip erase runs only when all protect level bits are zero
// R21 - Bit 6 is quad lane flag; when set, hardware protection is disabled
// R22 - Bit 7 is status lock; with protect pin low status writes are refused
// R23 - Single-byte opcodes 06, 04, 05, 9f, ab, sent MSB first
// R24 - A partial instruction byte is discarded without any state change
`ifndef SFW_REGS_SVH
`define SFW_REGS_SVH

`define SFW_CMD_LATCH_SET 8'h06
`define SFW_CMD_LATCH_CLEAR 8'h04
`define SFW_CMD_STATUS_READ 8'h05
`define SFW_CMD_STATUS_WRITE 8'h01
`define SFW_CMD_IDENT_READ 8'h9f
`define SFW_CMD_LEGACY_SIG 8'hab
`define SFW_CMD_PAIR_READ 8'h90
`define SFW_CMD_PAGE_PROGRAM 8'h02
`define SFW_CMD_QUAD_PROGRAM 8'h38
`define SFW_CMD_SECTOR_ERASE 8'h20
`define SFW_CMD_HALF_BLOCK_ERASE 8'h52
`define SFW_CMD_BLOCK_ERASE 8'hd8
`define SFW_CMD_CHIP_ERASE_A 8'h60
`define SFW_CMD_CHIP_ERASE_B 8'hc7
`define SFW_CMD_SUSPEND_A 8'h75
`define SFW_CMD_SUSPEND_B 8'hb0
`define SFW_CMD_RESUME_A 8'h7a
`define SFW_CMD_RESUME_B 8'h30
`define SFW_CMD_RESET_ENABLE 8'h66
`define SFW_CMD_RESET 8'h99
`define SFW_CMD_SECURITY_WRITE 8'h2f

// Status word bit positions
`define SFW_BIT_BUSY 0
`define SFW_BIT_LATCH 1
`define SFW_BIT_LEVEL_LO 2
`define SFW_BIT_LEVEL_HI 5
`define SFW_BIT_QUAD 6
`define SFW_BIT_LOCK 7
`define SFW_STATUS_RESET 8'h00

// Frame lengths in serial clock edges
`define SFW_LEN_OPCODE 12'd8
`define SFW_LEN_ONE_DATA 12'd16
`define SFW_LEN_TWO_DATA 12'd24
`define SFW_LEN_ADDR 12'd32
`define SFW_LEN_MAX 12'hfff

// Protected region: 64 KB block index taken from the address
`define SFW_BLK_MSB 20
`define SFW_BLK_LSB 16
`define SFW_BLK_COUNT 6'd32
`define SFW_LEVEL_ALL 4'd6

`endif

// ---- sfw_pkg.sv ----
// Types shared by the serial flash front-end
package sfw_pkg;
	typedef enum logic [2:0] {SFW_KIND_NONE, SFW_KIND_PROG, SFW_KIND_ERASE, SFW_KIND_CHIP, SFW_KIND_STATUS} sfw_kind_t;
	typedef enum logic [2:0] {SFW_RESP_NONE, SFW_RESP_STATUS, SFW_RESP_IDENT, SFW_RESP_SIG, SFW_RESP_PAIR} sfw_resp_t;
	typedef enum logic [1:0] {SFW_EX_IDLE, SFW_EX_RUN, SFW_EX_SUSP} sfw_exec_state_t;
endpackage : sfw_pkg

// ---- sfw_if.sv ----
// Carrier between the front-end top, its serial link engine and its operation timer
`timescale 1ns/10ps
interface sfw_if;
	import sfw_pkg::*;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [7:0] wdata;
	logic [11:0] nbits;
	logic [7:0] status;
	logic start;
	sfw_kind_t kind;
	logic suspend;
	logic resume;
	logic abort;
	logic busy;
	logic done;
	logic suspended;
	sfw_kind_t run_kind;
	modport link (output opcode, addr, wdata, nbits, input status);
	modport core_link (input opcode, addr, wdata, nbits, output status);
	modport exec (input start, kind, suspend, resume, abort, output busy, done, suspended, run_kind);
	modport core_exec (output start, kind, suspend, resume, abort, input busy, done, suspended, run_kind);
endinterface : sfw_if

// ---- sfw_link.sv ----
// Serial link engine on the serial clock: takes in instruction bytes, shifts responses out
`timescale 1ns/10ps
`include "sfw_regs.svh"
module sfw_link #(
	parameter logic [7:0] MAKER_ID = 8'h4e,
	parameter logic [7:0] TYPE_ID = 8'h61,
	parameter logic [7:0] DENSITY_ID = 8'h17
) (
	// Link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Reset
	input wire logic rst_n,
	// Core side
	sfw_if.link bus
);
	import sfw_pkg::*;

	logic link_clr;
	logic in_frame;
	logic [11:0] nbits;
	logic [7:0] shift;
	logic [7:0] next_byte;
	logic [7:0] stat_s1;
	logic [7:0] stat_s2;
	sfw_resp_t mode;
	logic [1:0] id_sel;
	logic [2:0] idx;
	logic pair_sel;

	// Chip select high ends the frame and idles the output stage
	assign link_clr = cs_n | ~rst_n;
	assign next_byte = {shift[6:0], si};
	assign idx = 3'(3'h7 - nbits[2:0]);
	assign pair_sel = nbits[3] ^ bus.addr[0];

	always_ff @(posedge sclk or posedge link_clr) begin
		if (link_clr) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	// Frame fields survive chip select so the core can read them afterwards
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			nbits <= 12'h000;
		end else if (!in_frame) begin
			nbits <= 12'h001;
		end else if (nbits != `SFW_LEN_MAX) begin
			nbits <= 12'(nbits + 12'h001);
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shift <= 8'h00;
		end else begin
			shift <= next_byte; // R23
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			bus.opcode <= 8'h00;
			bus.addr <= 24'h000000;
			bus.wdata <= 8'h00;
		end else if (in_frame) begin
			if (nbits == 12'(`SFW_LEN_OPCODE - 12'h001)) begin
				bus.opcode <= next_byte;
			end
			if (nbits == 12'(`SFW_LEN_ONE_DATA - 12'h001)) begin
				bus.wdata <= next_byte;
			end
			if (nbits == 12'(`SFW_LEN_ONE_DATA - 12'h001) || nbits == 12'(`SFW_LEN_TWO_DATA - 12'h001) ||
				nbits == 12'(`SFW_LEN_ADDR - 12'h001)) begin
				bus.addr <= {bus.addr[15:0], next_byte}; // R10
			end
		end
	end

	assign bus.nbits = nbits;

	// Status word is quasi-static; during a frame only a completing operation moves it, busy bit first, then the latch bit
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_s1 <= `SFW_STATUS_RESET;
			stat_s2 <= `SFW_STATUS_RESET;
		end else begin
			stat_s1 <= bus.status;
			stat_s2 <= stat_s1;
		end
	end

	always_ff @(posedge sclk or posedge link_clr) begin
		if (link_clr) begin
			mode <= SFW_RESP_NONE;
		end else if (nbits == 12'(`SFW_LEN_OPCODE - 12'h001)) begin
			case (next_byte)
				`SFW_CMD_STATUS_READ: mode <= SFW_RESP_STATUS; // R13
				`SFW_CMD_IDENT_READ: mode <= stat_s2[`SFW_BIT_BUSY] ? SFW_RESP_NONE : SFW_RESP_IDENT; // R6
				`SFW_CMD_LEGACY_SIG: mode <= SFW_RESP_SIG;
				`SFW_CMD_PAIR_READ: mode <= SFW_RESP_PAIR;
				default: mode <= SFW_RESP_NONE;
			endcase
		end
	end

	// Identification byte index wraps after three bytes
	always_ff @(posedge sclk or posedge link_clr) begin
		if (link_clr) begin
			id_sel <= 2'h0;
		end else if (nbits[2:0] == 3'h7 && nbits > `SFW_LEN_OPCODE) begin
			id_sel <= (id_sel == 2'h2) ? 2'h0 : 2'(id_sel + 2'h1); // R5
		end
	end

	always_ff @(negedge sclk or posedge link_clr) begin
		if (link_clr) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			case (mode)
				SFW_RESP_STATUS: begin
					so <= stat_s2[idx];
					so_oe <= 1'b1;
				end
				SFW_RESP_IDENT: begin
					so <= (id_sel == 2'h0) ? MAKER_ID[idx] : (id_sel == 2'h1) ? TYPE_ID[idx] : DENSITY_ID[idx]; // R7
					so_oe <= 1'b1;
				end
				SFW_RESP_SIG: begin
					so <= DENSITY_ID[idx]; // R8
					so_oe <= (nbits >= `SFW_LEN_ADDR);
				end
				SFW_RESP_PAIR: begin
					so <= pair_sel ? DENSITY_ID[idx] : MAKER_ID[idx]; // R11 R12
					so_oe <= (nbits >= `SFW_LEN_ADDR);
				end
				default: begin
					so <= 1'b0;
					so_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule : sfw_link

// ---- sfw_exec.sv ----
// Self-timed operation timer for program, erase and status write cycles
`timescale 1ns/10ps
`include "sfw_regs.svh"
module sfw_exec #(
	parameter logic [11:0] PROG_CYCLES = 12'd200,
	parameter logic [11:0] ERASE_CYCLES = 12'd1000,
	parameter logic [11:0] CHIP_CYCLES = 12'd4000,
	parameter logic [11:0] STATUS_CYCLES = 12'd100
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Core side
	sfw_if.exec bus
);
	import sfw_pkg::*;

	sfw_exec_state_t state;
	logic [11:0] remain;

	function automatic logic [11:0] kind_cycles(input sfw_kind_t k);
		case (k)
			SFW_KIND_PROG: kind_cycles = PROG_CYCLES;
			SFW_KIND_ERASE: kind_cycles = ERASE_CYCLES;
			SFW_KIND_CHIP: kind_cycles = CHIP_CYCLES;
			default: kind_cycles = STATUS_CYCLES;
		endcase
	endfunction : kind_cycles

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= SFW_EX_IDLE;
			remain <= 12'h000;
			bus.run_kind <= SFW_KIND_NONE;
		end else begin
			case (state)
				SFW_EX_IDLE: begin
					if (bus.start) begin
						state <= SFW_EX_RUN;
						remain <= kind_cycles(bus.kind);
						bus.run_kind <= bus.kind;
					end
				end
				SFW_EX_RUN: begin
					if (bus.abort) begin
						state <= SFW_EX_IDLE;
					end else if (bus.suspend && bus.run_kind != SFW_KIND_STATUS) begin
						state <= SFW_EX_SUSP;
					end else if (remain <= 12'h001) begin
						state <= SFW_EX_IDLE;
					end else begin
						remain <= 12'(remain - 12'h001);
					end
				end
				SFW_EX_SUSP: begin
					if (bus.abort) begin
						state <= SFW_EX_IDLE;
					end else if (bus.resume) begin
						state <= SFW_EX_RUN;
					end
				end
				default: state <= SFW_EX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus.done <= 1'b0;
		end else begin
			bus.done <= (state == SFW_EX_RUN) && !bus.abort && !(bus.suspend && bus.run_kind != SFW_KIND_STATUS) &&
				(remain <= 12'h001);
		end
	end

	assign bus.busy = (state == SFW_EX_RUN); // R15
	assign bus.suspended = (state == SFW_EX_SUSP);
endmodule : sfw_exec

// ---- sfw_top.sv ----
// Serial flash command front-end: write latch, identification reads and status word
`timescale 1ns/10ps
`include "sfw_regs.svh"
module sfw_top #(
	parameter logic [7:0] MAKER_ID = 8'h4e, // Arbitrary value
	parameter logic [7:0] TYPE_ID = 8'h61, // Arbitrary value
	parameter logic [7:0] DENSITY_ID = 8'h17, // Arbitrary value
	parameter logic [11:0] PROG_CYCLES = 12'd200,
	parameter logic [11:0] ERASE_CYCLES = 12'd1000,
	parameter logic [11:0] CHIP_CYCLES = 12'd4000,
	parameter logic [11:0] STATUS_CYCLES = 12'd100
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Write protect pin
	input wire logic wp_n,
	// Observation
	output logic [7:0] flash_status_word,
	output logic hardware_lock_state
);
	import sfw_pkg::*;

	sfw_if bus ();

	logic cs_s1;
	logic cs_s2;
	logic cs_s3;
	logic wp_s1;
	logic wp_s2;
	logic frame_end;
	logic [7:0] op;
	logic [11:0] len;
	logic exact_op;
	logic write_latch_flag;
	logic [3:0] protect_level;
	logic quad_lane_flag;
	logic status_lock_flag;
	logic reset_armed;
	logic is_prog;
	logic is_erase;
	logic is_chip;
	logic is_status_write;
	logic prog_len_ok;
	logic status_len_ok;
	logic may_modify;
	logic go_prog;
	logic go_erase;
	logic go_chip;
	logic go_status;
	logic do_suspend;
	logic do_resume;
	logic do_soft_reset;
	logic do_security;
	logic latch_set_req;
	logic latch_clear_req;
	logic kind_clears;

	// True when the 64 KB block of the address falls in the protected top region
	function automatic logic in_protected(input logic [3:0] level, input logic [23:0] a);
		logic [5:0] span;
		logic [5:0] blk;
		span = 6'h00;
		blk = {1'b0, a[`SFW_BLK_MSB:`SFW_BLK_LSB]};
		if (level == 4'h0) begin
			in_protected = 1'b0;
		end else if (level >= `SFW_LEVEL_ALL) begin
			in_protected = 1'b1;
		end else begin
			span = 6'(6'h01 << (level - 4'h1));
			in_protected = (blk >= 6'(`SFW_BLK_COUNT - span));
		end
	endfunction : in_protected

	sfw_link #(
		.MAKER_ID(MAKER_ID),
		.TYPE_ID(TYPE_ID),
		.DENSITY_ID(DENSITY_ID)
	) u_link (
		.sclk(sclk),
		.cs_n(cs_n),
		.si(si),
		.so(so),
		.so_oe(so_oe),
		.rst_n(rst_n),
		.bus(bus.link)
	);

	sfw_exec #(
		.PROG_CYCLES(PROG_CYCLES),
		.ERASE_CYCLES(ERASE_CYCLES),
		.CHIP_CYCLES(CHIP_CYCLES),
		.STATUS_CYCLES(STATUS_CYCLES)
	) u_exec (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.bus(bus.exec)
	);

	// Chip select and protect pin cross into the system clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
		end else begin
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
		end else begin
			wp_s1 <= wp_n;
			wp_s2 <= wp_s1;
		end
	end

	// Frame fields are stable here: the serial clock stands still with chip select high
	assign frame_end = cs_s2 & ~cs_s3;
	assign op = bus.opcode;
	assign len = bus.nbits;
	assign exact_op = frame_end && (len == `SFW_LEN_OPCODE); // R24

	assign is_prog = (op == `SFW_CMD_PAGE_PROGRAM) || (op == `SFW_CMD_QUAD_PROGRAM);
	assign is_erase = (op == `SFW_CMD_SECTOR_ERASE) || (op == `SFW_CMD_HALF_BLOCK_ERASE) ||
		(op == `SFW_CMD_BLOCK_ERASE);
	assign is_chip = (op == `SFW_CMD_CHIP_ERASE_A) || (op == `SFW_CMD_CHIP_ERASE_B);
	assign is_status_write = (op == `SFW_CMD_STATUS_WRITE);
	assign prog_len_ok = (len > `SFW_LEN_ADDR) && (len[2:0] == 3'h0);
	assign status_len_ok = (len == `SFW_LEN_ONE_DATA) || (len == `SFW_LEN_TWO_DATA);

	// Quad lane mode disables the protect pin and with it the hardware lock
	assign hardware_lock_state = status_lock_flag && !wp_s2 && !quad_lane_flag; // R21 R22

	assign may_modify = frame_end && write_latch_flag && !bus.busy && !bus.suspended; // R2 R16
	assign go_prog = may_modify && is_prog && prog_len_ok && !in_protected(protect_level, bus.addr); // R17 R19
	assign go_erase = may_modify && is_erase && (len == `SFW_LEN_ADDR) &&
		!in_protected(protect_level, bus.addr); // R17 R19
	assign go_chip = may_modify && is_chip && (len == `SFW_LEN_OPCODE) && (protect_level == 4'h0); // R20
	assign go_status = may_modify && is_status_write && status_len_ok && !hardware_lock_state; // R22

	assign do_suspend = exact_op && bus.busy && bus.run_kind != SFW_KIND_STATUS &&
		((op == `SFW_CMD_SUSPEND_A) || (op == `SFW_CMD_SUSPEND_B));
	assign do_resume = exact_op && bus.suspended && ((op == `SFW_CMD_RESUME_A) || (op == `SFW_CMD_RESUME_B));
	assign do_soft_reset = exact_op && reset_armed && (op == `SFW_CMD_RESET);
	assign do_security = exact_op && write_latch_flag && !bus.busy && (op == `SFW_CMD_SECURITY_WRITE);

	assign latch_set_req = exact_op && !bus.busy && (op == `SFW_CMD_LATCH_SET); // R1 R23
	assign latch_clear_req = exact_op && !bus.busy && (op == `SFW_CMD_LATCH_CLEAR); // R3 R23
	assign kind_clears = bus.done && (bus.run_kind != SFW_KIND_NONE);

	assign bus.start = go_prog | go_erase | go_chip | go_status;
	assign bus.kind = go_status ? SFW_KIND_STATUS : go_chip ? SFW_KIND_CHIP : go_erase ? SFW_KIND_ERASE :
		go_prog ? SFW_KIND_PROG : SFW_KIND_NONE;
	assign bus.suspend = do_suspend;
	assign bus.resume = do_resume;
	assign bus.abort = do_soft_reset;

	// Setting wins over any clear that lands in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			write_latch_flag <= 1'b0; // R4
		end else if (latch_set_req) begin
			write_latch_flag <= 1'b1; // R1
		end else if (latch_clear_req || kind_clears || do_suspend || do_soft_reset || do_security) begin
			write_latch_flag <= 1'b0; // R3 R4
		end
	end

	// Non-volatile bits restart at zero; only a status write changes them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			protect_level <= 4'h0;
			quad_lane_flag <= 1'b0;
			status_lock_flag <= 1'b0;
		end else if (go_status) begin
			protect_level <= bus.wdata[`SFW_BIT_LEVEL_HI:`SFW_BIT_LEVEL_LO]; // R19
			quad_lane_flag <= bus.wdata[`SFW_BIT_QUAD]; // R21
			status_lock_flag <= bus.wdata[`SFW_BIT_LOCK]; // R22
		end
	end

	// Reset needs its enable as the immediately preceding complete instruction
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reset_armed <= 1'b0;
		end else if (frame_end && len >= `SFW_LEN_OPCODE) begin
			reset_armed <= exact_op && (op == `SFW_CMD_RESET_ENABLE);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flash_status_word <= `SFW_STATUS_RESET;
		end else begin
			flash_status_word <= {status_lock_flag, quad_lane_flag, protect_level, write_latch_flag,
				bus.busy}; // R15 R16
		end
	end

	assign bus.status = flash_status_word;
endmodule : sfw_top

// ---- sfw_sva.sv ----
// Port checker for the serial flash front-end
`timescale 1ns/10ps
module sfw_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	// Protect pin and status
	input wire logic wp_n,
	input wire logic [7:0] flash_status_word,
	input wire logic hardware_lock_state
);
	logic [7:0] bit_cnt;
	logic [7:0] opc;
	// Rising sclk edges in this frame and its first byte
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt <= 8'h00;
		end else if (bit_cnt != 8'hff) begin
			bit_cnt <= bit_cnt + 8'h01;
		end
	end
	always_ff @(posedge sclk) begin
		if (bit_cnt < 8'h08) begin
			opc <= {opc[6:0], si};
		end
	end
	sequence s_busy_end;
		$fell(flash_status_word[0]);
	endsequence
	sequence s_latch_gone;
		##[0:2] !flash_status_word[1];
	endsequence
	property p_oe_idle;
		@(posedge clk_sys) disable iff (!rst_n) cs_n |-> !so_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("so_oe high outside a frame");
	property p_oe_late;
		@(posedge sclk) disable iff (!rst_n) so_oe |-> bit_cnt >= 8'h08;
	endproperty
	a_oe_late: assert property (p_oe_late) else $error("so_oe before a full opcode");
	property p_id_rep;
		@(posedge sclk) disable iff (!rst_n) (so_oe && opc == 8'h9f && bit_cnt >= 8'h20) |-> so == $past(so, 24);
	endproperty
	a_id_rep: assert property (p_id_rep) else $error("ident bytes not repeating");
	property p_sig_rep;
		@(posedge sclk) disable iff (!rst_n) (so_oe && opc == 8'hab && bit_cnt >= 8'h28) |-> so == $past(so, 8);
	endproperty
	a_sig_rep: assert property (p_sig_rep) else $error("signature not repeating");
	property p_pair_rep;
		@(posedge sclk) disable iff (!rst_n) (so_oe && opc == 8'h90 && bit_cnt >= 8'h30) |-> so == $past(so, 16);
	endproperty
	a_pair_rep: assert property (p_pair_rep) else $error("pair bytes not alternating");
	property p_lock_pin;
		@(posedge clk_sys) disable iff (!rst_n) hardware_lock_state |-> !$past(wp_n, 2);
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("lock state with protect pin high");
	property p_lock_bits;
		@(posedge clk_sys) disable iff (!rst_n)
			hardware_lock_state |-> ##1 (flash_status_word[7] && !flash_status_word[6]);
	endproperty
	a_lock_bits: assert property (p_lock_bits) else $error("lock state without lock bit");
	property p_level_hold;
		@(posedge clk_sys) disable iff (!rst_n)
			$changed(flash_status_word[7:2]) |-> flash_status_word[0] || $past(flash_status_word[0]);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("protect bits changed outside a write");
	property p_latch_end;
		@(posedge clk_sys) disable iff (!rst_n) s_busy_end |-> s_latch_gone;
	endproperty
	a_latch_end: assert property (p_latch_end) else $error("latch kept after operation");
	property p_latch_idle;
		@(posedge clk_sys) disable iff (!rst_n) $rose(flash_status_word[1]) |-> !flash_status_word[0];
	endproperty
	a_latch_idle: assert property (p_latch_idle) else $error("latch set while busy");
endmodule : sfw_sva
bind sfw_top sfw_sva sfw_sva_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
	.wp_n(wp_n), .flash_status_word(flash_status_word), .hardware_lock_state(hardware_lock_state)
);

// ---- sfw_host.sv ----
// Serial host controller model on the far side of the flash link
`timescale 1ns/10ps
module sfw_host (
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// One frame: ntx bits from tx[31] down, then nrx bits taken on rising sclk
	task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx, output logic [31:0] rx,
		output logic oe);
		rx = 32'h0;
		oe = 1'b0;
		#7 cs_n = 1'b0;
		for (int i = 0; i < ntx + nrx; i++) begin
			si = (i < ntx) ? tx[31 - i] : ~si;
			#16 sclk = 1'b1;
			if (i >= ntx) begin
				rx = {rx[30:0], so_oe ? so : 1'b1}; // Released line floats to its pull-up
				oe = oe | so_oe;
			end
			#16 sclk = 1'b0;
		end
		#16 cs_n = 1'b1;
		si = ~si;
		#400;
	endtask : xfer
	// Poll busy down, then read once more so the latch is seen after it settles
	task automatic wait_idle(output logic [7:0] st);
		logic [31:0] rx;
		logic oe;
		st = 8'hff;
		for (int n = 0; n < 100 && st[0] !== 1'b0; n++) begin
			xfer(32'h05000000, 8, 8, rx, oe);
			st = rx[7:0];
		end
		xfer(32'h05000000, 8, 8, rx, oe);
		st = rx[7:0];
	endtask : wait_idle
endmodule : sfw_host

// ---- sfw_top_tb.sv ----
// Self-checking bench for the serial flash command front-end
`timescale 1ns/10ps
module sfw_top_tb;
	typedef struct {
		logic [31:0] tx;
		int ntx;
		int nrx;
		logic [31:0] exp_rx;
		logic [7:0] exp_st;
	} sfw_row_t;
	localparam logic [7:0] MAKER = 8'h4e; // Arbitrary value
	localparam logic [7:0] KIND = 8'h61; // Arbitrary value
	localparam logic [7:0] DENS = 8'h17; // Arbitrary value
	logic clk_sys;
	logic rst_n;
	logic wp_n;
	logic sclk;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic [7:0] flash_status_word;
	logic hardware_lock_state;
	logic [31:0] rx;
	logic oe;
	logic [7:0] st;
	int n_errors;
	int samples_checked;
	sfw_row_t rows [7] = '{
		'{32'h9f000000, 8, 32, {MAKER, KIND, DENS, MAKER}, 8'h00},
		'{32'hab000000, 32, 16, {16'h0, DENS, DENS}, 8'h00},
		'{32'h90000000, 32, 32, {MAKER, DENS, MAKER, DENS}, 8'h00},
		'{32'h90000001, 32, 32, {DENS, MAKER, DENS, MAKER}, 8'h00},
		'{32'h06000000, 8, 0, 32'h0, 8'h02},
		'{32'h05000000, 8, 16, 32'h0202, 8'h02},
		'{32'h04000000, 8, 0, 32'h0, 8'h00}
	};
	sfw_top #(.MAKER_ID(MAKER), .TYPE_ID(KIND), .DENSITY_ID(DENS), .PROG_CYCLES(12'd10),
		.ERASE_CYCLES(12'd10), .CHIP_CYCLES(12'd300), .STATUS_CYCLES(12'd40)) sfw_top_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
		.wp_n(wp_n), .flash_status_word(flash_status_word), .hardware_lock_state(hardware_lock_state)
	);
	sfw_host sfw_host_inst (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic check_st(input logic [7:0] want);
		check({24'h0, flash_status_word}, {24'h0, want});
	endtask : check_st
	task automatic frame(input logic [31:0] tx, input int ntx, input int nrx);
		sfw_host_inst.xfer(tx, ntx, nrx, rx, oe);
		@(negedge clk_sys);
	endtask : frame
	task automatic idle;
		sfw_host_inst.wait_idle(st);
		@(negedge clk_sys);
	endtask : idle
	task automatic set_wp(input logic v);
		@(posedge clk_sys);
		wp_n <= v;
		repeat (4) @(negedge clk_sys);
	endtask : set_wp
	task automatic results;
		$display("Checks %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	initial begin
		#500000;
		n_errors++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		n_errors = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(negedge clk_sys);
		check({22'h0, so_oe, hardware_lock_state, flash_status_word}, 32'h0);
		for (int i = 0; i < 7; i++) begin
			frame(rows[i].tx, rows[i].ntx, rows[i].nrx);
			check(rx, rows[i].exp_rx);
			check_st(rows[i].exp_st);
		end
		// Cut-short opcodes
		frame(32'h06000000, 7, 0);
		check_st(8'h00);
		frame(32'h06000000, 8, 0);
		frame(32'h04000000, 7, 0);
		check_st(8'h02);
		// Status write protects everything, latch drops at the end
		frame(32'h01180000, 16, 0);
		check({30'h0, flash_status_word[1:0]}, 32'h3);
		idle();
		check({24'h0, st}, 32'h18);
		frame(32'h01000000, 16, 0);
		check_st(8'h18);
		frame(32'h06000000, 8, 0);
		frame(32'h20000000, 32, 0);
		check_st(8'h1a);
		frame(32'h60000000, 8, 0);
		check_st(8'h1a);
		frame(32'h01000000, 16, 0);
		idle();
		check({24'h0, st}, 32'h00);
		// Chip erase with no protection, reads while it runs
		frame(32'h06000000, 8, 0);
		frame(32'hc7000000, 8, 0);
		check({30'h0, flash_status_word[1:0]}, 32'h3);
		frame(32'h9f000000, 8, 24);
		check({31'h0, oe}, 32'h0);
		check(rx, 32'h00ffffff);
		frame(32'h05000000, 8, 8);
		check(rx, 32'h03);
		idle();
		check({24'h0, st}, 32'h00);
		// Program, then chip erase with suspend, resume and soft reset
		frame(32'h06000000, 8, 0);
		frame(32'h02000000, 32, 8);
		check({30'h0, flash_status_word[1:0]}, 32'h3);
		idle();
		check({24'h0, st}, 32'h00);
		frame(32'h06000000, 8, 0);
		frame(32'hc7000000, 8, 0);
		frame(32'h75000000, 8, 0);
		check_st(8'h00);
		frame(32'h7a000000, 8, 0);
		check_st(8'h01);
		frame(32'h75000000, 8, 0);
		frame(32'h06000000, 8, 0);
		check_st(8'h02);
		frame(32'h66000000, 8, 0);
		frame(32'h99000000, 8, 0);
		check_st(8'h00);
		// Lock bit with the protect pin
		frame(32'h06000000, 8, 0);
		frame(32'h01800000, 16, 0);
		idle();
		check({24'h0, st}, 32'h80);
		set_wp(1'b0);
		check({31'h0, hardware_lock_state}, 32'h1);
		frame(32'h06000000, 8, 0);
		frame(32'h01000000, 16, 0);
		check_st(8'h82);
		set_wp(1'b1);
		check({31'h0, hardware_lock_state}, 32'h0);
		frame(32'h01c00000, 16, 0);
		idle();
		check({24'h0, st}, 32'hc0);
		set_wp(1'b0);
		check({31'h0, hardware_lock_state}, 32'h0);
		// Reset in mid-run clears the word
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (3) @(negedge clk_sys);
		check({23'h0, hardware_lock_state, flash_status_word}, 32'h0);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(negedge clk_sys);
		frame(32'h06000000, 8, 0);
		check_st(8'h02);
		results();
	end
endmodule : sfw_top_tb
